// >>> timer_pkg.sv
// Constants, encodings and register map of the dual 8-bit timer pair
package timer_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_RUN = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_LCMP = 8'h08;
    localparam logic [7:0] ADDR_UCMP = 8'h0C;
    localparam logic [7:0] ADDR_FFCR = 8'h10;
    localparam logic [7:0] ADDR_COUNT = 8'h14;
    localparam logic [7:0] ADDR_ISTS = 8'h18;
    localparam logic [7:0] ADDR_IMSK = 8'h1C;
    // Run register bits
    localparam int RUN_LOWER = 0;
    localparam int RUN_UPPER = 1;
    localparam int RUN_PRESC = 2;
    // Mode register field positions
    localparam int MODE_LCLK_LSB = 0;
    localparam int MODE_UCLK_LSB = 2;
    localparam int MODE_PWM_LSB = 4;
    localparam int MODE_PAIR_LSB = 6;
    // Flip-flop control register field positions
    localparam int FF_CMD_LSB = 0;
    localparam int FF_INV_EN = 2;
    localparam int FF_SRC = 3;
    localparam int FF_DBUF = 4;
    localparam int FF_STATE = 5;
    // Interrupt bits
    localparam int IRQ_UPPER = 0;
    localparam int IRQ_LOWER = 1;
    localparam int IRQ_W = 2;
    // Reset values and counter constants
    localparam logic [2:0] RUN_RST = 3'h0;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [4:0] FFCR_RST = 5'h00;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    // Prescaler tap widths: tap period is 2**bits system clocks
    localparam int PRESC_W = 11;
    localparam int PRESC_T1_BITS = 3;
    localparam int PRESC_T4_BITS = 5;
    localparam int PRESC_T16_BITS = 7;
    localparam int PRESC_T256_BITS = 11;
    // PWM period tops (2**n - 1)
    localparam logic [7:0] PWM_TOP6 = 8'h3F;
    localparam logic [7:0] PWM_TOP7 = 8'h7F;
    localparam logic [7:0] PWM_TOP8 = 8'hFF;

    typedef enum logic [1:0] {MODE_DUAL = 2'b00, MODE_16 = 2'b01, MODE_PPG = 2'b10, MODE_PWM = 2'b11} pair_mode_e;
    typedef enum logic [1:0] {LCLK_EXT = 2'b00, LCLK_T1 = 2'b01, LCLK_T4 = 2'b10, LCLK_T16 = 2'b11} lower_clk_e;
    typedef enum logic [1:0] {UCLK_MATCH = 2'b00, UCLK_T1 = 2'b01, UCLK_T16 = 2'b10, UCLK_T256 = 2'b11} upper_clk_e;
    typedef enum logic [1:0] {PWM_P6 = 2'b01, PWM_P7 = 2'b10, PWM_P8 = 2'b11} pwm_period_e;
    typedef enum logic [1:0] {FF_INVERT = 2'b00, FF_SET = 2'b01, FF_CLEAR = 2'b10, FF_KEEP = 2'b11} ff_cmd_e;
endpackage

// >>> timer_pair.sv
// Dual 8-bit timer pair with 16-bit, pulse generator and PWM modes
//
// Operation
// - Dual mode: upper counter may count lower compare matches
// - Mode field 01 joins both timers into one 16-bit interval timer
// - 16-bit mode: upper counter clocked by lower overflow, ignoring clock select
// - 16-bit mode: lower compare is low byte, upper compare high byte
// - 16-bit mode: lower compare write suspends compare, upper write resumes; write low first
// - 16-bit mode: lower match pulses but does not clear lower counter
// - Both matching: clear both counters, raise upper interrupt, toggle if enabled
// - Pulse generator: lower timer alone drives square wave; upper timer unavailable
// - Pulse generator: toggle output when lower counter equals either compare
// - Pulse generator double buffer loads lower compare on upper compare match
// - PWM only on lower timer, up to 8 bits; upper timer stays independent
// - PWM: toggle on lower compare match and on selected 2^n overflow
// - PWM: lower counter clears on selected 2^n overflow
// - PWM double buffer loads lower compare at each 2^n overflow
// - Mode codes: 00 dual, 01 16-bit, 10 pulse generator, 11 PWM
module timer_pair
    import timer_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Wishbone slave
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    // Pins
    input wire logic ext_clk_i,
    output logic flipflop_out_pin_o,
    // Interrupts
    output logic upper_timer_irq_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////
    // State
    logic [2:0] run_q;
    logic [7:0] mode_q;
    logic [7:0] lcmp_q, lbuf_q, ucmp_q;
    logic [7:0] lower_q, upper_q;
    logic [4:0] ffcr_q;
    logic ff_q, cmp_en_q, ack_q, uirq_q;
    logic [31:0] dat_q;
    logic [IRQ_W-1:0] ists_q, imsk_q;
    logic [PRESC_W-1:0] presc_q;
    logic ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q;

    ////////////////////////////////////////////////////////////////
    // Bus decode; one wait state, ack drops the cycle after
    wire bus_req = cyc_i & stb_i & ~ack_q;
    wire wr = bus_req & we_i & sel_i[0];
    wire wr_run = wr & (adr_i == ADDR_RUN);
    wire wr_mode = wr & (adr_i == ADDR_MODE);
    wire wr_lcmp = wr & (adr_i == ADDR_LCMP);
    wire wr_ucmp = wr & (adr_i == ADDR_UCMP);
    wire wr_ffcr = wr & (adr_i == ADDR_FFCR);
    wire wr_ists = wr & (adr_i == ADDR_ISTS);
    wire wr_imsk = wr & (adr_i == ADDR_IMSK);

    // Mode decode
    pair_mode_e pair_mode;
    lower_clk_e lclk_sel;
    upper_clk_e uclk_sel;
    pwm_period_e pwm_sel;
    ff_cmd_e ff_cmd;
    assign pair_mode = pair_mode_e'(mode_q[MODE_PAIR_LSB +: 2]);
    assign lclk_sel = lower_clk_e'(mode_q[MODE_LCLK_LSB +: 2]);
    assign uclk_sel = upper_clk_e'(mode_q[MODE_UCLK_LSB +: 2]);
    assign pwm_sel = pwm_period_e'(mode_q[MODE_PWM_LSB +: 2]);
    assign ff_cmd = ff_cmd_e'(dat_i[FF_CMD_LSB +: 2]);
    wire is_dual = (pair_mode == MODE_DUAL);
    wire is_16 = (pair_mode == MODE_16);
    wire is_ppg = (pair_mode == MODE_PPG);
    wire is_pwm = (pair_mode == MODE_PWM);
    wire inv_en = ffcr_q[FF_INV_EN];
    wire dbuf_en = ffcr_q[FF_DBUF];

    ////////////////////////////////////////////////////////////////
    // Prescaler taps
    wire tick_t1 = run_q[RUN_PRESC] & (&presc_q[PRESC_T1_BITS-1:0]);
    wire tick_t4 = run_q[RUN_PRESC] & (&presc_q[PRESC_T4_BITS-1:0]);
    wire tick_t16 = run_q[RUN_PRESC] & (&presc_q[PRESC_T16_BITS-1:0]);
    wire tick_t256 = run_q[RUN_PRESC] & (&presc_q[PRESC_T256_BITS-1:0]);
    // External clock counts on a filtered rising edge
    wire ext_agree = (ext_s2_q == ext_s3_q);
    wire ext_tick = ext_agree & ext_s3_q & ~ext_lvl_q;

    ////////////////////////////////////////////////////////////////
    // Lower timer
    wire lower_src = (lclk_sel == LCLK_EXT) ? ext_tick :
                     (lclk_sel == LCLK_T1) ? tick_t1 :
                     (lclk_sel == LCLK_T4) ? tick_t4 : tick_t16;
    // Pulse generator waits for the upper run bit as well
    wire lower_tick = run_q[RUN_LOWER] & lower_src & ~(is_ppg & ~run_q[RUN_UPPER]);
    wire [7:0] lower_inc = lower_q + CNT_ONE;
    wire lower_ovf = lower_tick & (lower_q == CNT_MAX);
    wire lower_match = lower_tick & (lower_inc == lcmp_q) & (~is_16 | cmp_en_q);
    // PWM period end
    wire [7:0] pwm_top = (pwm_sel == PWM_P6) ? PWM_TOP6 :
                         (pwm_sel == PWM_P7) ? PWM_TOP7 : PWM_TOP8;
    wire pwm_ovf = lower_tick & is_pwm & (lower_q == pwm_top);
    // Pulse generator period end on upper compare; relies on lower < upper
    wire ppg_period = lower_tick & is_ppg & (lower_inc == ucmp_q);

    ////////////////////////////////////////////////////////////////
    // Upper timer
    wire upper_sel = (uclk_sel == UCLK_MATCH) ? lower_match :
                     (uclk_sel == UCLK_T1) ? tick_t1 :
                     (uclk_sel == UCLK_T16) ? tick_t16 : tick_t256;
    wire upper_src = is_16 ? lower_ovf : upper_sel;
    // Upper counter is idle in pulse generator mode
    wire upper_tick = run_q[RUN_UPPER] & upper_src & ~is_ppg;
    wire [7:0] upper_inc = upper_q + CNT_ONE;
    wire [7:0] upper_next = upper_tick ? upper_inc : upper_q;
    wire upper_match = upper_tick & ~is_16 & (upper_inc == ucmp_q);
    // Full 16-bit match: low byte lower compare, high byte upper compare
    wire match16 = is_16 & lower_match & (upper_next == ucmp_q);

    // Flip-flop toggle source per mode
    wire dual_tgl = ffcr_q[FF_SRC] ? upper_match : lower_match;
    wire hw_tgl_src = is_dual ? dual_tgl :
                      is_16 ? match16 :
                      is_ppg ? (lower_match | ppg_period) :
                      (lower_match | pwm_ovf);
    wire hw_tgl = inv_en & hw_tgl_src;
    wire buf_load = dbuf_en & (ppg_period | pwm_ovf);
    wire buf_mode = dbuf_en & (is_ppg | is_pwm);
    wire upper_ev = upper_match | match16;
    wire lower_clr = (is_dual & lower_match) | match16 | ppg_period | pwm_ovf;

    ////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero
    wire [31:0] rdata = (adr_i == ADDR_RUN) ? {29'h0, run_q} :
                        (adr_i == ADDR_MODE) ? {24'h0, mode_q} :
                        (adr_i == ADDR_LCMP) ? {24'h0, lcmp_q} :
                        (adr_i == ADDR_UCMP) ? {24'h0, ucmp_q} :
                        (adr_i == ADDR_FFCR) ? {26'h0, ff_q, ffcr_q} :
                        (adr_i == ADDR_COUNT) ? {16'h0, upper_q, lower_q} :
                        (adr_i == ADDR_ISTS) ? {30'h0, ists_q} :
                        (adr_i == ADDR_IMSK) ? {30'h0, imsk_q} : 32'h0000_0000;

    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign flipflop_out_pin_o = ff_q;
    assign upper_timer_irq_o = uirq_q;
    // Level interrupt while any unmasked status bit stands
    assign irq_o = |(ists_q & imsk_q);

    ////////////////////////////////////////////////////////////////
    // Bus response
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req;
            dat_q <= bus_req ? rdata : dat_q;
        end
    end

    // External clock synchroniser and filter
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            ext_lvl_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_clk_i;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            ext_lvl_q <= ext_agree ? ext_s3_q : ext_lvl_q;
        end
    end

    // Prescaler, held at zero while stopped
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !run_q[RUN_PRESC]) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + PRESC_W'(1);
        end
    end

    // Control registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            run_q <= RUN_RST;
            mode_q <= MODE_RST;
            ffcr_q <= FFCR_RST;
            imsk_q <= '0;
        end else begin
            if (wr_run) run_q <= dat_i[2:0];
            if (wr_mode) mode_q <= dat_i[7:0];
            if (wr_ffcr) ffcr_q <= dat_i[4:0];
            if (wr_imsk) imsk_q <= dat_i[IRQ_W-1:0];
        end
    end

    // Compare registers; buffered writes only where a buffer is used
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            lcmp_q <= CMP_RST;
            lbuf_q <= CMP_RST;
            ucmp_q <= CMP_RST;
            cmp_en_q <= 1'b1;
        end else begin
            if (wr_lcmp) lbuf_q <= dat_i[7:0];
            if (wr_lcmp && !buf_mode) lcmp_q <= dat_i[7:0];
            else if (buf_load) lcmp_q <= lbuf_q;
            if (wr_ucmp) ucmp_q <= dat_i[7:0];
            if (wr_lcmp) cmp_en_q <= 1'b0;
            else if (wr_ucmp) cmp_en_q <= 1'b1;
        end
    end

    // Counters; a stopped timer is held at zero
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !run_q[RUN_LOWER]) begin
            lower_q <= CNT_ZERO;
        end else if (lower_tick) begin
            lower_q <= lower_clr ? CNT_ZERO : lower_inc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !run_q[RUN_UPPER]) begin
            upper_q <= CNT_ZERO;
        end else if (match16 || upper_match) begin
            upper_q <= CNT_ZERO;
        end else if (upper_tick) begin
            upper_q <= upper_inc;
        end
    end

    // Timer flip-flop; a software command wins over a hardware toggle
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ff_q <= 1'b0;
        end else if (wr_ffcr && ff_cmd != FF_KEEP) begin
            ff_q <= (ff_cmd == FF_SET) | ((ff_cmd == FF_INVERT) & ~ff_q);
        end else if (hw_tgl) begin
            ff_q <= ~ff_q;
        end
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ists_q <= '0;
            uirq_q <= 1'b0;
        end else begin
            ists_q <= (ists_q & ~(wr_ists ? dat_i[IRQ_W-1:0] : '0)) | {lower_match, upper_ev};
            uirq_q <= upper_ev;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_both_cleared;
        lower_q == CNT_ZERO && upper_q == CNT_ZERO;
    endsequence

    sequence s_irq_seen;
        upper_timer_irq_o ##0 ists_q[IRQ_UPPER];
    endsequence

    property p_upper_on_match;
        is_dual && uclk_sel == UCLK_MATCH && run_q[RUN_UPPER] && !wr_run && lower_match && !upper_match
            |=> upper_q == $past(upper_inc);
    endproperty
    a_upper_on_match: assert property (p_upper_on_match) else $error("upper did not count lower match");

    property p_carry16;
        is_16 && run_q[RUN_UPPER] && !wr_run && lower_ovf && !match16 |=> upper_q == $past(upper_inc);
    endproperty
    a_carry16: assert property (p_carry16) else $error("upper did not take lower overflow");

    property p_clear16;
        match16 && !wr_run |=> s_both_cleared and s_irq_seen;
    endproperty
    a_clear16: assert property (p_clear16) else $error("16-bit match did not clear and interrupt");

    property p_suspend;
        wr_lcmp |=> !cmp_en_q ##0 (!lower_match || !is_16);
    endproperty
    a_suspend: assert property (p_suspend) else $error("compare not suspended after low write");

    property p_resume;
        wr_ucmp && !wr_lcmp |=> cmp_en_q;
    endproperty
    a_resume: assert property (p_resume) else $error("compare not resumed after high write");

    property p_no_clear16;
        is_16 && lower_match && !match16 && !wr_run |=> lower_q == $past(lower_inc);
    endproperty
    a_no_clear16: assert property (p_no_clear16) else $error("16-bit lower match cleared counter");

    property p_ppg_toggle;
        is_ppg && inv_en && (lower_match || ppg_period) && !wr_ffcr |=> ff_q != $past(ff_q);
    endproperty
    a_ppg_toggle: assert property (p_ppg_toggle) else $error("pulse output did not toggle");

    property p_ppg_buffer;
        is_ppg && dbuf_en && ppg_period |=> lcmp_q == $past(lbuf_q);
    endproperty
    a_ppg_buffer: assert property (p_ppg_buffer) else $error("buffer not loaded at period end");

    property p_pwm_toggle;
        is_pwm && inv_en && pwm_ovf && !wr_ffcr |=> ff_q != $past(ff_q);
    endproperty
    a_pwm_toggle: assert property (p_pwm_toggle) else $error("PWM output did not toggle on overflow");

    property p_pwm_clear;
        pwm_ovf |=> lower_q == CNT_ZERO;
    endproperty
    a_pwm_clear: assert property (p_pwm_clear) else $error("PWM overflow did not clear counter");

    property p_pwm_buffer;
        is_pwm && dbuf_en && pwm_ovf |=> lcmp_q == $past(lbuf_q);
    endproperty
    a_pwm_buffer: assert property (p_pwm_buffer) else $error("PWM buffer not loaded");

    property p_tick_only;
        run_q[RUN_LOWER] && !wr_run && !lower_tick |=> $stable(lower_q);
    endproperty
    a_tick_only: assert property (p_tick_only) else $error("lower counter moved without tick");

endmodule

// >>> pin_load.sv
// Load model on the timer flip-flop pin that measures high and low times
module pin_load (
    // Clock
    input wire logic clk_i,
    // Pin from the timer
    input wire logic pin_i,
    // Last completed level lengths in clock cycles
    output int hi_len_o,
    output int lo_len_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_q = 1'b0;
    int run_q = 0;
    ////////////////////////////////////////////////////////////////////////
    // Length of the level just ended, stored when the pin flips
    always @(posedge clk_i) begin
        run_q <= run_q + 1;
        last_q <= pin_i;
        if (pin_i !== last_q) begin
            run_q <= 1;
            if (last_q === 1'b1) hi_len_o <= run_q;
            else lo_len_o <= run_q;
        end
    end
endmodule

// >>> tb_top.sv
// Bench for the timer pair: bus tasks, mode scenarios and interrupt checks
module tb_top;
    import timer_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, ext_clk_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic [3:0] sel_i = 4'hF;
    logic ack_o, flipflop_out_pin_o, upper_timer_irq_o, irq_o;
    int n_errors = 0, n_checks = 0, n_irq = 0, cyc_cnt = 0, last_irq = 0, gap = 0, hi, lo, s, a, p;
    timer_pair timer_pair_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .ext_clk_i(ext_clk_i), .flipflop_out_pin_o(flipflop_out_pin_o),
        .upper_timer_irq_o(upper_timer_irq_o), .irq_o(irq_o));
    pin_load pin_load_inst (.clk_i(clk_i), .pin_i(flipflop_out_pin_o), .hi_len_o(hi), .lo_len_o(lo));
    ////////////////////////////////////////////////////////////////////////
    // 125 MHz clock
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    // Interrupt pulse counter and spacing between the last two pulses
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (upper_timer_irq_o === 1'b1) begin
            n_irq <= n_irq + 1;
            gap <= cyc_cnt - last_irq;
            last_irq <= cyc_cnt;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Classic cycle: hold the request until ack is sampled high at a rising edge
    task automatic wb(input logic [7:0] ad, input logic w, input logic [7:0] d);
        int i;
        @(posedge clk_i);
        adr_i <= ad;
        we_i <= w;
        dat_i <= {24'h000000, d};
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        i = 0;
        // Ack and read data are taken at the same rising edge, then released
        do begin
            @(posedge clk_i);
            i++;
        end while (ack_o !== 1'b1 && i < 16);
        if (ack_o !== 1'b1) begin
            n_errors++;
            end_of_test();
        end else begin
            q = dat_o;
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
            we_i <= 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        wb(ad, 1'b1, d);
    endtask
    // Bounded wait for a number of further interrupt pulses
    task automatic wait_irqs(input int n);
        int i;
        int st;
        st = n_irq;
        for (i = 0; i < 20000 && n_irq < st + n; i++) @(posedge clk_i);
        if (n_irq < st + n) begin
            n_errors++;
            end_of_test();
        end
    endtask
    task automatic restart(input logic [7:0] mode);
        wr(ADDR_RUN, 8'h00);
        wr(ADDR_MODE, mode);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        // Reset values, unmapped address included
        for (a = 0; a <= 32; a += 4) begin
            wb(8'(a), 1'b0, 8'h00);
            chk("reset read", 32'h0, q);
        end
        wr(ADDR_MODE, 8'h01);
        wr(ADDR_LCMP, 8'h80);
        wr(ADDR_RUN, 8'h03);
        repeat (100) @(posedge clk_i);
        wb(ADDR_COUNT, 1'b0, 8'h00);
        chk("count without prescaler", 32'h0, q);
        $display("Test reset done");
        // Dual mode: upper counts lower matches, 2 x 3 ticks of 8 clocks
        restart(8'h01);
        wr(ADDR_LCMP, 8'h02);
        wr(ADDR_UCMP, 8'h03);
        wr(ADDR_RUN, 8'h07);
        wait_irqs(3);
        chk("dual irq gap", 32'd48, 32'(gap));
        $display("Test dual done");
        // 16-bit mode with upper select on the slowest tap, low byte first
        restart(8'h4D);
        wr(ADDR_FFCR, 8'h06);
        wr(ADDR_LCMP, 8'h02);
        wr(ADDR_UCMP, 8'h01);
        wr(ADDR_RUN, 8'h07);
        wait_irqs(3);
        chk("16-bit irq gap", 32'd2064, 32'(gap));
        chk("16-bit pin high", 32'd2064, 32'(hi));
        wr(ADDR_LCMP, 8'h01);
        s = n_irq;
        repeat (3000) @(posedge clk_i);
        chk("suspended irqs", 32'(s), 32'(n_irq));
        wr(ADDR_RUN, 8'h00);
        wr(ADDR_UCMP, 8'h02);
        wr(ADDR_RUN, 8'h07);
        wait_irqs(2);
        chk("resumed irq gap", 32'd4104, 32'(gap));
        $display("Test 16-bit done");
        // Interrupt status, mask and level output
        wr(ADDR_RUN, 8'h00);
        wr(ADDR_IMSK, 8'h00);
        chk("masked irq", 32'h0, 32'(irq_o));
        wb(ADDR_ISTS, 1'b0, 8'h00);
        chk("status upper", 32'h1, q & 32'h1);
        wr(ADDR_IMSK, 8'h01);
        chk("unmasked irq", 32'h1, 32'(irq_o));
        wr(ADDR_ISTS, 8'h03);
        chk("cleared irq", 32'h0, 32'(irq_o));
        wb(ADDR_ISTS, 1'b0, 8'h00);
        chk("cleared status", 32'h0, q);
        $display("Test interrupt done");
        // Dual mode on the external count input, pin fed by upper matches
        restart(8'h00);
        wr(ADDR_FFCR, 8'h0D);
        wb(ADDR_FFCR, 1'b0, 8'h00);
        chk("ff set command", 32'h2D, q);
        wr(ADDR_FFCR, 8'h0C);
        wb(ADDR_FFCR, 1'b0, 8'h00);
        chk("ff invert command", 32'h0C, q);
        wr(ADDR_LCMP, 8'h02);
        wr(ADDR_UCMP, 8'h02);
        wr(ADDR_RUN, 8'h03);
        s = n_irq;
        // Seven slow pulses, each level long enough for the input filter
        repeat (7) begin
            repeat (4) @(posedge clk_i);
            ext_clk_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            ext_clk_i <= 1'b0;
        end
        repeat (8) @(posedge clk_i);
        wb(ADDR_COUNT, 1'b0, 8'h00);
        chk("ext count", 32'h0101, q);
        chk("ext upper irqs", 32'(s + 1), 32'(n_irq));
        chk("ext upper pin", 32'h1, 32'(flipflop_out_pin_o));
        $display("Test external clock done");
        // Pulse generator: toggles at compare 2 and 6, low value below high
        restart(8'h81);
        wr(ADDR_FFCR, 8'h06);
        wr(ADDR_LCMP, 8'h02);
        wr(ADDR_UCMP, 8'h06);
        wr(ADDR_RUN, 8'h07);
        repeat (200) @(posedge clk_i);
        chk("ppg period", 32'd48, 32'(hi + lo));
        chk("ppg short level", 32'd16, 32'((hi < lo) ? hi : lo));
        wr(ADDR_FFCR, 8'h17);
        wr(ADDR_LCMP, 8'h03);
        repeat (200) @(posedge clk_i);
        chk("ppg buffered high", 32'd24, 32'(hi));
        chk("ppg buffered low", 32'd24, 32'(lo));
        $display("Test pulse generator done");
        // PWM for each period code, upper timer running on its own
        for (p = 1; p <= 3; p++) begin
            restart(8'hC5 | 8'(p << 4));
            wr(ADDR_FFCR, 8'h06);
            wr(ADDR_LCMP, 8'h10);
            wr(ADDR_UCMP, 8'h04);
            wr(ADDR_RUN, 8'h07);
            repeat (3 * (8 << (p + 5)) + 64) @(posedge clk_i);
            chk("pwm period", 32'(8 << (p + 5)), 32'(hi + lo));
            chk("pwm compare level", 32'd128, 32'((hi < lo) ? hi : lo));
            chk("pwm upper gap", 32'd32, 32'(gap));
        end
        restart(8'hD5);
        wr(ADDR_FFCR, 8'h16);
        wr(ADDR_LCMP, 8'h10);
        wr(ADDR_RUN, 8'h07);
        wr(ADDR_LCMP, 8'h20);
        repeat (1600) @(posedge clk_i);
        chk("pwm buffered high", 32'd256, 32'(hi));
        chk("pwm buffered low", 32'd256, 32'(lo));
        $display("Test pwm done");
        end_of_test();
    end
endmodule
